// *** rxd_top.sv ***
// rxd_top.sv: serial video receiver with pixel fifo and apb registers
`timescale 1ns/1ps
`include "rxd_map.svh"
module rxd_fifo #(
    parameter int W     = 27,
    parameter int DEPTH = 16
) (
    // clock, reset, flush
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         flush,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          wr, rd;
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign level     = cnt_r;
    always_comb begin
        wr      = in_valid && in_ready;
        rd      = out_valid && out_ready;
        wp_nxt  = flush ? '0 : (wr ? wp_r + 1'b1 : wp_r);
        rp_nxt  = flush ? '0 : (rd ? rp_r + 1'b1 : rp_r);
        cnt_nxt = flush ? '0 : cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // storage needs no reset
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule : rxd_fifo
module rxd_top import rxd_pkg::*; #(
    parameter int IDLE_CYC    = `RXD_IDLE_CYC,
    parameter int LOCK_FRAMES = `RXD_LOCK_FRAMES,
    parameter int DEPTH       = `RXD_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // serial link
    input  wire logic        link_clk_in,
    input  wire logic [2:0]  data_lane_in,
    // parallel video
    input  wire logic        pixel_ready,
    output logic             pclk_out,
    output logic [23:0]      rgb_out,
    output logic             vertical_sync_out,
    output logic             horizontal_sync_out,
    output logic             display_enable_out
);
    localparam int LW = $clog2(DEPTH) + 1;
    // ----------------------------------------
    // state
    // ----------------------------------------
    rxd_ctrl_t   ctrl_r, ctrl_nxt;
    rxd_state_t  state_r, state_nxt;
    logic        lclk_r, ovf_r, ovf_nxt;
    logic [4:0]  bit_cnt_r, bit_cnt_nxt;
    logic [15:0] idle_r, idle_nxt;
    logic [3:0]  lock_r, lock_nxt;
    logic [29:0] sreg_r, sreg_nxt;
    logic [31:0] frm_r, frm_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic        pclk_nxt, vs_nxt, hs_nxt, de_nxt;
    logic [23:0] rgb_nxt;
    logic [1:0]  ls;
    logic [4:0]  bpl, half;
    logic        rise, good, lost, push, pop, in_rdy, out_vld, acc, wr_en;
    rxd_pix_t    in_pix, out_pix;
    logic [LW-1:0] lvl;
    function automatic logic [23:0] rev24(input logic [23:0] v);
        rev24 = {<<{v}};
    endfunction : rev24
    // ----------------------------------------
    // link timing and lock
    // ----------------------------------------
    always_comb begin
        ls = {ctrl_r.link_select_high_bit, ctrl_r.link_select_low_bit};
        case (ls)
            `RXD_LS_TWO:   bpl = `RXD_BPL_TWO;
            `RXD_LS_THREE: bpl = `RXD_BPL_THREE;
            default:       bpl = `RXD_BPL_ONE;
        endcase
        half = bpl >> 1;
        rise = link_clk_in && !lclk_r;
        // period must match bits per lane
        good = rise && (bit_cnt_r == bpl - 5'h01);
        // no edge for a while means idle
        lost = (idle_r == 16'(IDLE_CYC));
        bit_cnt_nxt = rise ? 5'h00 : (bit_cnt_r == 5'h1f ? bit_cnt_r : bit_cnt_r + 5'h01);
        idle_nxt    = rise ? 16'h0000 : (lost ? idle_r : idle_r + 16'h0001);
        lock_nxt    = 4'h0;
        if (state_r == st_acq) begin
            lock_nxt = good ? (lock_r == 4'(LOCK_FRAMES) ? lock_r : lock_r + 4'h1)
                            : (rise ? 4'h0 : lock_r);
        end
        state_nxt = state_r;
        case (state_r)
            st_shut: state_nxt = st_stby;
            st_stby: state_nxt = rise ? st_acq : st_stby;
            // wait for lock before passing data
            st_acq:  state_nxt = lost ? st_stby
                               : ((good && lock_r == 4'(LOCK_FRAMES)) ? st_act : st_acq);
            st_act:  state_nxt = lost ? st_stby : ((rise && !good) ? st_acq : st_act);
            default: state_nxt = st_shut;
        endcase
        // enable low or reserved select forces shutdown
        if (!ctrl_r.receiver_enable || ls == 2'h3) begin
            state_nxt = st_shut;
        end
    end
    // ----------------------------------------
    // deserializer
    // ----------------------------------------
    always_comb begin
        // shift lanes in, oldest bit highest
        case (ls)
            `RXD_LS_TWO:   sreg_nxt = {sreg_r[27:0], data_lane_in[1:0]};
            `RXD_LS_THREE: sreg_nxt = {sreg_r[26:0], data_lane_in};
            default:       sreg_nxt = {sreg_r[28:0], data_lane_in[0]};
        endcase
        if (state_r == st_shut || state_r == st_stby) begin
            sreg_nxt = '0;
        end
        // low 28 bits: rgb, zero, vs, hs, de
        in_pix = {sreg_r[27:4], sreg_r[2:0]};
        // only the active state delivers words
        push = (state_r == st_act) && good;
        pop  = (state_r == st_act) && (bit_cnt_r == half) && out_vld && pixel_ready;
        frm_nxt = frm_r + 32'(push && in_rdy);
    end
    // overrun costs a word, not the link timing
    rxd_fifo #(.W($bits(rxd_pix_t)), .DEPTH(DEPTH)) u_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .flush     (state_r != st_act),
        .in_valid  (push),
        .in_ready  (in_rdy),
        .in_data   (in_pix),
        .out_valid (out_vld),
        .out_ready (pop),
        .out_data  (out_pix),
        .level     (lvl)
    );
    // ----------------------------------------
    // output bus
    // ----------------------------------------
    always_comb begin
        pclk_nxt = 1'b0;
        de_nxt   = 1'b0;
        vs_nxt   = 1'b1;
        hs_nxt   = 1'b1;
        rgb_nxt  = 24'hffffff;
        if (state_nxt == st_act && state_r == st_act) begin
            // pixel clock divided from bit count
            pclk_nxt = (bit_cnt_nxt < half);
            de_nxt   = display_enable_out;
            vs_nxt   = vertical_sync_out;
            hs_nxt   = horizontal_sync_out;
            rgb_nxt  = rgb_out;
            if (pop) begin
                de_nxt  = out_pix.de;
                vs_nxt  = out_pix.vsync;
                hs_nxt  = out_pix.hsync;
                rgb_nxt = ctrl_r.bus_reverse
                        ? rev24({out_pix.red, out_pix.green, out_pix.blue})
                        : {out_pix.red, out_pix.green, out_pix.blue};
            end
        end
    end
    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    always_comb begin
        // one wait state keeps prdata registered
        pready_nxt  = psel && penable && !pready;
        acc         = psel && penable && pready;
        wr_en       = acc && pwrite;
        prdata_nxt  = 32'h0;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            case (paddr)
                `RXD_CTRL_OFS: prdata_nxt = {28'h0, ctrl_r};
                `RXD_STAT_OFS: prdata_nxt = {16'h0, 3'h0, 5'(lvl), 3'h0, ovf_r,
                                             1'b0, (state_r == st_act), state_r};
                `RXD_CNT_OFS:  prdata_nxt = frm_r;
                default:       pslverr_nxt = 1'b1;
            endcase
        end
        ctrl_nxt = ctrl_r;
        if (wr_en && paddr == `RXD_CTRL_OFS) begin
            ctrl_nxt = pwdata[3:0];
        end
        // overrun set beats the write-one clear
        ovf_nxt = ovf_r;
        if (wr_en && paddr == `RXD_STAT_OFS && pwdata[`RXD_STAT_OVF_BIT]) begin
            ovf_nxt = 1'b0;
        end
        if (push && !in_rdy) begin
            ovf_nxt = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r              <= `RXD_CTRL_RST;
            state_r             <= st_shut;
            lclk_r              <= 1'b1;
            ovf_r               <= 1'b0;
            bit_cnt_r           <= 5'h00;
            idle_r              <= 16'h0000;
            lock_r              <= 4'h0;
            sreg_r              <= '0;
            frm_r               <= 32'h0;
            prdata              <= 32'h0;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
            pclk_out            <= 1'b0;
            rgb_out             <= 24'hffffff;
            vertical_sync_out   <= 1'b1;
            horizontal_sync_out <= 1'b1;
            display_enable_out  <= 1'b0;
        end else begin
            ctrl_r              <= ctrl_nxt;
            state_r             <= state_nxt;
            lclk_r              <= link_clk_in;
            ovf_r               <= ovf_nxt;
            bit_cnt_r           <= bit_cnt_nxt;
            idle_r              <= idle_nxt;
            lock_r              <= lock_nxt;
            sreg_r              <= sreg_nxt;
            frm_r               <= frm_nxt;
            prdata              <= prdata_nxt;
            pready              <= pready_nxt;
            pslverr             <= pslverr_nxt;
            pclk_out            <= pclk_nxt;
            rgb_out             <= rgb_nxt;
            vertical_sync_out   <= vs_nxt;
            horizontal_sync_out <= hs_nxt;
            display_enable_out  <= de_nxt;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_SHUT_ON_DISABLE: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_r.receiver_enable |=> state_r == st_shut)
        else $error("enable low did not shut down");
    AST_SHUT_NO_SHIFT: assert property (@(posedge core_clk) disable iff (rst)
        state_r == st_shut |=> sreg_r == '0)
        else $error("shifter took input in shutdown");
    AST_PUSH_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
        push |-> state_r == st_act && $past(state_r) != st_shut)
        else $error("word delivered outside active state");
    AST_RESERVED_SEL: assert property (@(posedge core_clk) disable iff (rst)
        ls == 2'h3 |=> state_r == st_shut)
        else $error("reserved select did not stop reception");
    AST_LOCK_FIRST: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state_r == st_act) |-> $past(lock_r) == 4'(LOCK_FRAMES) && $past(good))
        else $error("active entered without lock");
    AST_WORD_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
        push |-> bit_cnt_r == bpl - 5'h01 ##1 bit_cnt_r == 5'h00)
        else $error("word taken off the pixel period");
    AST_PCLK_DIV: assert property (@(posedge core_clk) disable iff (rst)
        state_r == st_act && $past(state_r) == st_act && $stable(ls)
        |-> pclk_out == (bit_cnt_r < half))
        else $error("pixel clock not divided from bit count");
    AST_IDLE_PATTERN: assert property (@(posedge core_clk) disable iff (rst)
        state_r == st_stby |-> !pclk_out && !display_enable_out && rgb_out == 24'hffffff
        && vertical_sync_out && horizontal_sync_out)
        else $error("idle pattern not held without link clock");
    AST_ACQ_PATTERN: assert property (@(posedge core_clk) disable iff (rst)
        state_r == st_acq |-> !pclk_out && !display_enable_out && rgb_out == 24'hffffff)
        else $error("data passed before lock");
    AST_STBY_ON_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        state_r == st_act && lost && ctrl_r.receiver_enable && ls != 2'h3
        |=> state_r == st_stby)
        else $error("lost link clock did not give standby");
    AST_REVERSE: assert property (@(posedge core_clk) disable iff (rst)
        pop && ctrl_r.bus_reverse && state_nxt == st_act
        |=> rgb_out == rev24({$past(out_pix.red), $past(out_pix.green), $past(out_pix.blue)})
        && display_enable_out == $past(out_pix.de))
        else $error("reversed bus order wrong");
endmodule : rxd_top

// *** rxd_map.svh ***
// rxd_map.svh: offsets, fields, reset values and timing counts of the receiver
`ifndef RXD_MAP_SVH
`define RXD_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RXD_CTRL_OFS     12'h000
`define RXD_STAT_OFS     12'h004
`define RXD_CNT_OFS      12'h008
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RXD_CTRL_EN_BIT  0
`define RXD_CTRL_LS_LO   1
`define RXD_CTRL_REV_BIT 3
`define RXD_STAT_LCK_BIT 2
`define RXD_STAT_OVF_BIT 4
`define RXD_STAT_LVL_LO  8
`define RXD_CTRL_RST     4'h0
// ----------------------------------------
// link select codes and bits per lane
// ----------------------------------------
`define RXD_LS_ONE       2'h0
`define RXD_LS_TWO       2'h1
`define RXD_LS_THREE     2'h2
`define RXD_BPL_ONE      5'h1e
`define RXD_BPL_TWO      5'h0f
`define RXD_BPL_THREE    5'h0a
// ----------------------------------------
// timing
// ----------------------------------------
`define RXD_CLK_NS       100
`define RXD_IDLE_NS      6400
`define RXD_IDLE_CYC     (`RXD_IDLE_NS / `RXD_CLK_NS)
`define RXD_LOCK_FRAMES  4
`define RXD_FIFO_DEPTH   16
`endif

// *** rxd_pkg.sv ***
// rxd_pkg.sv: types shared by the receiver
package rxd_pkg;
    typedef enum logic [1:0] {st_shut, st_stby, st_acq, st_act} rxd_state_t;

    typedef struct packed {
        logic       bus_reverse;
        logic       link_select_high_bit;
        logic       link_select_low_bit;
        logic       receiver_enable;
    } rxd_ctrl_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       vsync;
        logic       hsync;
        logic       de;
    } rxd_pix_t;
endpackage : rxd_pkg

// *** rxd_tx_model.sv ***
// rxd_tx_model.sv: serializer model driving the receiver link clock and lanes
`timescale 1ns/1ps
`include "rxd_map.svh"

module rxd_tx_model (
    // control from the bench
    input  wire logic       core_clk,
    input  wire logic       run,
    input  wire logic [1:0] ls,
    // serial link
    output logic            link_clk,
    output logic [2:0]      lane
);
    // ----------------------------------------
    // jitter words, one or two lanes then three lanes
    // ----------------------------------------
    // fixed repeating sequences
    logic [27:0] tbl [2][32] = '{
        '{28'h0000001, 28'h000fff3, 28'h8008001, 28'h0030037, 28'he00e001, 28'h00ff001,
          28'h007e001, 28'h003c001, 28'h0018001, 28'h1c7e381, 28'h3333331, 28'h555aaa5,
          28'h6dbdb61, 28'h0777771, 28'h555aaa3, 28'h0aaaaa5, 28'h0555553, 28'haaa5555,
          28'h8888881, 28'h9242491, 28'haaa5571, 28'hcccccc1, 28'he3e1c71, 28'hffe7ff1,
          28'hffc3ff1, 28'hff81ff1, 28'hfe00ff1, 28'h1ff1ff1, 28'hffcffc3, 28'h7ff7ff1,
          28'hfff0007, 28'h0fffff1},
        '{28'h0000001, 28'h0000001, 28'h0000003, 28'h0101013, 28'h0303033, 28'h0707073,
          28'h1818183, 28'he7e7e71, 28'h3535351, 28'h0202021, 28'h5454543, 28'ha5a5a51,
          28'hadadad1, 28'h0555551, 28'ha6a2aa3, 28'ha6a2aa5, 28'h0555553, 28'h0555555,
          28'haaaaaa1, 28'h5252521, 28'h5a5a5a1, 28'hababab1, 28'hfdfcfd1, 28'hcaaaca1,
          28'h1818181, 28'he7e7e71, 28'hf8f8f81, 28'hfcfcfc1, 28'hfefefe1, 28'h0fffff1,
          28'h0fffff5, 28'h0fffff5}};
    logic [4:0]  cnt = 5'h0;
    logic [4:0]  idx = 5'h0;
    logic [4:0]  bpl;
    logic [29:0] sh = 30'h0;
    logic [29:0] w;

    initial begin
        link_clk = 1'b1;
        lane     = 3'h5;
    end
    assign bpl = (ls == 2'h0) ? `RXD_BPL_ONE : (ls == 2'h1) ? `RXD_BPL_TWO : `RXD_BPL_THREE;
    assign w = (cnt == 5'h0) ? {2'h0, tbl[ls == 2'h2][idx]} : sh;
    always @(posedge core_clk) begin
        if (!run) begin
            link_clk <= 1'b1;
            lane     <= ~lane;
            cnt      <= 5'h0;
            idx      <= 5'h0;
        end else begin
            // lanes per select, top bits first
            link_clk <= (cnt < bpl / 5'h2);
            lane     <= (ls == 2'h0) ? {~lane[2:1], w[29]}
                      : (ls == 2'h1) ? {~lane[2], w[29:28]} : w[29:27];
            sh       <= w << (ls + 2'h1);
            cnt      <= (cnt == bpl - 5'h1) ? 5'h0 : cnt + 5'h1;
            idx      <= (cnt == bpl - 5'h1) ? idx + 5'h1 : idx;
        end
    end
endmodule : rxd_tx_model

// *** rxd_top_test.sv ***
// rxd_top_test.sv: self-checking bench for the serial video receiver
`timescale 1ns/1ps
`include "rxd_map.svh"

module rxd_top_test import rxd_pkg::*; ;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pixel_ready = 1'b1, run = 1'b0, rev = 1'b0, watch = 1'b0, have = 1'b0, pp = 1'b0;
    logic pready, pslverr, err, link_clk_in, pclk_out;
    logic vertical_sync_out, horizontal_sync_out, display_enable_out;
    logic [1:0]  ls = 2'h1;
    logic [2:0]  data_lane_in;
    logic [4:0]  bpl_e;
    logic [11:0] paddr = 12'h0;
    logic [23:0] rgb_out;
    logic [27:0] prev, got;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          n_errors = 0, tests_run = 0, gap = 0;

    always #50 core_clk = ~core_clk;
    assign bpl_e = (ls == 2'h0) ? `RXD_BPL_ONE : (ls == 2'h1) ? `RXD_BPL_TWO : `RXD_BPL_THREE;

    // short idle and lock counts keep the run brief
    rxd_top #(.IDLE_CYC(40), .LOCK_FRAMES(2), .DEPTH(`RXD_FIFO_DEPTH)) u_rxd_top (
        .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link_clk_in, .data_lane_in, .pixel_ready, .pclk_out, .rgb_out,
        .vertical_sync_out, .horizontal_sync_out, .display_enable_out);
    rxd_tx_model u_rxd_tx_model (
        .core_clk(core_clk), .run(run), .ls(ls), .link_clk(link_clk_in), .lane(data_lane_in));

    // ----------------------------------------
    // bus cycles and comparisons
    // ----------------------------------------
    task automatic check32(input logic [31:0] exp, input logic [31:0] act);
        tests_run++;
        if (act !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: expected %h, got %h", $time, exp, act);
        end
    endtask : check32

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check32(e, rd & m);
    endtask : rdchk

    task automatic wait_state(input rxd_state_t s);
        do bus(1'b0, `RXD_STAT_OFS, 32'h0); while (rd[1:0] !== s);
    endtask : wait_state

    // sampled mid-cycle, away from the launching edge
    task automatic idle();
        @(negedge core_clk);
        check32(32'h07fffffe, {4'h0, pclk_out, rgb_out, vertical_sync_out,
                               horizontal_sync_out, display_enable_out});
        @(posedge core_clk);
    endtask : idle

    function automatic logic [23:0] flip(input logic [23:0] v);
        for (int i = 0; i < 24; i++) flip[i] = v[23 - i];
    endfunction : flip

    // duplicates in the tables: any matching predecessor will do
    function automatic logic [27:0] succ(input logic [27:0] p, input logic [27:0] g);
        succ = 28'h0;
        for (int i = 0; i < 32; i++) begin
            if (u_rxd_tx_model.tbl[ls == 2'h2][i] === p) begin
                succ = u_rxd_tx_model.tbl[ls == 2'h2][(i + 1) % 32];
                if (succ === g) return succ;
            end
        end
    endfunction : succ

    always @(posedge core_clk) begin
        pp  <= pclk_out;
        gap <= (pclk_out && !pp) ? 1 : gap + 1;
        if (pclk_out && !pp) begin
            got = {rev ? flip(rgb_out) : rgb_out, 1'b0, vertical_sync_out,
                   horizontal_sync_out, display_enable_out};
            if (watch && have) begin
                check32({4'h0, succ(prev, got)}, {4'h0, got});
                check32({27'h0, bpl_e}, gap);
            end
            prev = got;
            have = watch;
        end
    end

    task automatic mode(input logic [1:0] m, input logic r);
        watch <= 1'b0;
        bus(1'b1, `RXD_CTRL_OFS, 32'h0);
        rdchk(`RXD_STAT_OFS, 32'h3, 32'h0);
        run <= 1'b0;
        ls  <= m;
        rev <= r;
        bus(1'b1, `RXD_CTRL_OFS, {28'h0, r, m, 1'b1});
        run <= 1'b1;
        wait_state(st_acq);
        idle();
        wait_state(st_act);
        rdchk(`RXD_STAT_OFS, 32'h4, 32'h4);
        repeat (120) @(posedge core_clk);
        watch <= 1'b1;
        repeat (360) @(posedge core_clk);
        $display("mode %0d reverse %0d done", m, r);
    endtask : mode

    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(`RXD_CTRL_OFS, 32'hf, 32'h0);
        rdchk(`RXD_STAT_OFS, 32'h7, 32'h0);
        rdchk(12'h00c, 32'hffffffff, 32'h0);
        check32(32'h1, {31'h0, err});
        idle();
        $display("reset test done");
        run <= 1'b1;
        repeat (200) @(posedge core_clk);
        rdchk(`RXD_CNT_OFS, 32'hffffffff, 32'h0);
        rdchk(`RXD_STAT_OFS, 32'h7, 32'h0);
        idle();
        $display("shutdown test done");
        mode(2'h1, 1'b0);
        // sink stalls long enough to overflow the fifo
        watch <= 1'b0;
        pixel_ready <= 1'b0;
        repeat (300) @(posedge core_clk);
        rdchk(`RXD_STAT_OFS, 32'h1f10, 32'h1010);
        pixel_ready <= 1'b1;
        repeat (30) @(posedge core_clk);
        bus(1'b1, `RXD_STAT_OFS, 32'h10);
        rdchk(`RXD_STAT_OFS, 32'h10, 32'h0);
        $display("stall test done");
        mode(2'h2, 1'b1);
        mode(2'h0, 1'b0);
        watch <= 1'b0;
        run <= 1'b0;
        wait_state(st_stby);
        idle();
        bus(1'b1, `RXD_CTRL_OFS, 32'h7);
        rdchk(`RXD_STAT_OFS, 32'h3, 32'h0);
        $display("standby and reserved test done");
        end_of_test();
    end
endmodule : rxd_top_test
